// ---- inc/exec_defines.svh ----
// Opcode, field, address and reset constants for the add/mask execution block
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH
`define OPC_HI_BIT        15
`define OPC_SUMC_LO_BIT   10
`define OPC_SUMC          6'h08
`define OPC_MASK_LO_BIT   8
`define OPC_MASK          8'h0b
`define DEST_BIT          9
`define ACCESS_BIT        8
`define INDEX_LIMIT       8'h5f
`define ACCESS_SPLIT      8'h80
`define ACCESS_HI_BANK    4'hf
`define W_RESET           8'h00
`define FLAG_RESET        1'b0
`endif

// ---- inc/exec_pkg.sv ----
// Types for the add/mask execution block
package exec_pkg;
   typedef enum logic [1:0]
   {
      PH_Q1 = 2'b00,
      PH_Q2 = 2'b01,
      PH_Q3 = 2'b11,
      PH_Q4 = 2'b10
   } phase_e;
   typedef logic [7:0]  byte_t;
   typedef logic [11:0] addr_t;
endpackage

// ---- rtl/add_carry_and_mask_exec.sv ----
// Execution of add-with-carry and mask-immediate instructions
`timescale 1ns/10ps
`include "exec_defines.svh"
// Summary of operation
// RULE1 - Add-with-carry sums W, memory byte and carry and sets all five flags.
// RULE2 - With destination bit zero the sum goes to W only.
// RULE3 - With destination bit one the sum is written back to the memory byte.
// RULE4 - With access bit zero the address resolves through the access bank.
// RULE5 - Access bit zero, extended set on, address up to 95: indexed offset.
// RULE6 - Access bit one joins the bank pointer to the file address.
// RULE7 - Mask-immediate ANDs the literal into W, updating N and Z only.
module add_carry_and_mask_exec
(
   input  wire logic            mclk,
   input  wire logic            reset_n,
   input  wire logic            instr_valid,
   input  wire logic [15:0]     instr_word,
   input  wire logic [3:0]      bank_pointer_register,
   input  wire logic            ext_set_en,
   input  wire exec_pkg::addr_t index_base,
   input  wire exec_pkg::byte_t mem_rdata,
   output exec_pkg::addr_t      mem_addr_ff,
   output logic                 mem_rd_ff,
   output logic                 mem_wr_ff,
   output exec_pkg::byte_t      mem_wdata_ff,
   output logic                 indexed_ff,
   output exec_pkg::byte_t      w_ff,
   output logic                 neg_flag_ff,
   output logic                 signed_wrap_flag_ff,
   output logic                 carry_flag_ff,
   output logic                 nibble_carry_flag_ff,
   output logic                 zero_flag_ff,
   output logic                 done_ff,
   output exec_pkg::phase_e     phase_ff
);
   import exec_pkg::*;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   logic    is_sumc;
   logic    is_mask;
   logic    op_sumc_ff;
   logic    op_mask_ff;
   logic    dest_ff;
   byte_t   lit_ff;
   byte_t   opnd_ff;
   addr_t   oper_addr;
   logic    indexed;
   phase_e  nxt_phase;

   assign is_sumc = instr_word[`OPC_HI_BIT:`OPC_SUMC_LO_BIT] == `OPC_SUMC;
   assign is_mask = instr_word[`OPC_HI_BIT:`OPC_MASK_LO_BIT] == `OPC_MASK;

   operand_addr u_operand_addr
   (
      .access_sel            (instr_word[`ACCESS_BIT]),
      .ext_set_en            (ext_set_en),
      .file_addr             (instr_word[7:0]),
      .bank_pointer_register (bank_pointer_register),
      .index_base            (index_base),
      .oper_addr             (oper_addr),
      .indexed               (indexed)
   );

   // ----------------------------------------
   // Quarter-cycle sequencer
   // ----------------------------------------
   always_comb
   begin
      unique case (phase_ff)
         PH_Q1: nxt_phase = (instr_valid && (is_sumc || is_mask)) ?
                            PH_Q2 : PH_Q1;
         PH_Q2: nxt_phase = PH_Q3;
         PH_Q3: nxt_phase = PH_Q4;
         PH_Q4: nxt_phase = PH_Q1;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         phase_ff <= PH_Q1;
      else
         phase_ff <= nxt_phase;
   end

   // Latch decoded instruction in Q1
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         op_sumc_ff  <= 1'b0;
         op_mask_ff  <= 1'b0;
         dest_ff     <= 1'b0;
         lit_ff      <= 8'h00;
         mem_addr_ff <= 12'h000;
         indexed_ff  <= 1'b0;
      end
      else if (phase_ff == PH_Q1 && instr_valid)
      begin
         op_sumc_ff  <= is_sumc;
         op_mask_ff  <= is_mask;
         dest_ff     <= instr_word[`DEST_BIT];
         lit_ff      <= instr_word[7:0];
         if (is_sumc)
         begin
            mem_addr_ff <= oper_addr; // RULE4 RULE5 RULE6
            indexed_ff  <= indexed;
         end
      end
   end

   // Memory read strobe in Q2, data captured at the end of Q2
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         mem_rd_ff <= 1'b0;
      else
         mem_rd_ff <= (phase_ff == PH_Q1) && instr_valid && is_sumc;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         opnd_ff <= 8'h00;
      else if (phase_ff == PH_Q2)
         opnd_ff <= op_sumc_ff ? mem_rdata : lit_ff;
   end

   // ----------------------------------------
   // Arithmetic in Q3, write in Q4
   // ----------------------------------------
   logic [8:0] sum9;
   logic [4:0] sum5;
   byte_t      res;
   logic       wrap;

   assign sum9 = {1'b0, w_ff} + {1'b0, opnd_ff} + {8'h00, carry_flag_ff};
   assign sum5 = {1'b0, w_ff[3:0]} + {1'b0, opnd_ff[3:0]} +
                 {4'h0, carry_flag_ff};
   assign wrap = (w_ff[7] == opnd_ff[7]) && (sum9[7] != w_ff[7]);
   assign res  = op_sumc_ff ? sum9[7:0] : (w_ff & opnd_ff);

   // ----------------------------------------
   // Working register and flags
   // ----------------------------------------

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         w_ff                 <= `W_RESET;
         neg_flag_ff          <= `FLAG_RESET;
         signed_wrap_flag_ff  <= `FLAG_RESET;
         carry_flag_ff        <= `FLAG_RESET;
         nibble_carry_flag_ff <= `FLAG_RESET;
         zero_flag_ff         <= `FLAG_RESET;
      end
      else if (phase_ff == PH_Q3)
      begin
         neg_flag_ff  <= res[7]; // RULE1 RULE7
         zero_flag_ff <= res == 8'h00; // RULE1 RULE7
         if (op_sumc_ff)
         begin
            signed_wrap_flag_ff  <= wrap; // RULE1
            carry_flag_ff        <= sum9[8]; // RULE1
            nibble_carry_flag_ff <= sum5[4]; // RULE1
         end
         if (op_mask_ff || !dest_ff)
            w_ff <= res; // RULE2 RULE7
      end
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mem_wr_ff    <= 1'b0;
         mem_wdata_ff <= 8'h00;
      end
      else
      begin
         mem_wr_ff <= (phase_ff == PH_Q3) && op_sumc_ff && dest_ff; // RULE3
         if (phase_ff == PH_Q3)
            mem_wdata_ff <= res; // RULE3
      end
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         done_ff <= 1'b0;
      else
         done_ff <= phase_ff == PH_Q3;
   end
endmodule

// ---- rtl/operand_addr.sv ----
// Operand address resolution for byte-oriented instructions
`timescale 1ns/10ps
`include "exec_defines.svh"
module operand_addr
(
   input  wire logic          access_sel,
   input  wire logic          ext_set_en,
   input  wire exec_pkg::byte_t file_addr,
   input  wire logic [3:0]    bank_pointer_register,
   input  wire exec_pkg::addr_t index_base,
   output exec_pkg::addr_t    oper_addr,
   output logic               indexed
);
   import exec_pkg::*;
   always_comb
   begin
      indexed = 1'b0;
      if (access_sel)
         oper_addr = {bank_pointer_register, file_addr}; // RULE6
      else if (ext_set_en && (file_addr <= `INDEX_LIMIT))
      begin
         indexed   = 1'b1;
         oper_addr = index_base + {4'h0, file_addr}; // RULE5
      end
      else if (file_addr < `ACCESS_SPLIT)
         oper_addr = {4'h0, file_addr}; // RULE4
      else
         oper_addr = {`ACCESS_HI_BANK, file_addr}; // RULE4
   end
endmodule

// ---- tb/exec_chk_assertions.sv ----
// Concurrent checks of the add/mask execution block
`timescale 1ns/10ps
module exec_chk
(
   input wire logic             mclk,
   input wire logic             reset_n,
   input wire logic             instr_valid,
   input wire logic [15:0]      instr_word,
   input wire logic [3:0]       bank_pointer_register,
   input wire logic             ext_set_en,
   input wire exec_pkg::addr_t  index_base,
   input wire exec_pkg::addr_t  mem_addr_ff,
   input wire logic             mem_rd_ff,
   input wire logic             mem_wr_ff,
   input wire exec_pkg::byte_t  w_ff,
   input wire logic             done_ff,
   input wire exec_pkg::phase_e phase_ff
);
   import exec_pkg::*;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   wire       tk = phase_ff == PH_Q1 && instr_valid;
   wire [7:0] f  = instr_word[7:0];
   rd_done_a: assert property (mem_rd_ff |-> ##2 done_ff)
      else $error("late done");
   dest_w_a: assert property
      (tk && instr_word[15:9] == 7'h10 |-> ##3 done_ff && !mem_wr_ff)
      else $error("stray write");
   dest_f_a: assert property (mem_wr_ff |-> done_ff && $stable(w_ff))
      else $error("bad write");
   access_a: assert property
      (mem_rd_ff && !$past(instr_word[8]) && !$past(ext_set_en)
       |-> mem_addr_ff == {{4{$past(f[7])}}, $past(f)})
      else $error("bad access");
   indexed_a: assert property
      (mem_rd_ff && !$past(instr_word[8]) && $past(ext_set_en) &&
       $past(f) <= 8'h5f |-> mem_addr_ff == $past(index_base) + $past(f))
      else $error("bad index");
   bank_a: assert property
      (mem_rd_ff && $past(instr_word[8])
       |-> mem_addr_ff == {$past(bank_pointer_register), $past(f)})
      else $error("bad bank");
   mask_w_a: assert property
      (tk && instr_word[15:8] == 8'h0b |-> ##3 w_ff == ($past(w_ff, 3) &
       $past(f, 3)))
      else $error("bad mask");
   rd_pulse_a: assert property
      (tk && instr_word[15:10] == 6'h08 |=> mem_rd_ff ##1 !mem_rd_ff)
      else $error("bad read pulse");
   mask_no_mem_a: assert property
      (tk && instr_word[15:8] == 8'h0b |=> !mem_rd_ff ##2 !mem_wr_ff)
      else $error("mask touched memory");
   done_phase_a: assert property (done_ff |-> phase_ff == PH_Q4)
      else $error("done outside last phase");
endmodule
bind add_carry_and_mask_exec exec_chk u_chk
(
   .mclk                  (mclk),
   .reset_n               (reset_n),
   .instr_valid           (instr_valid),
   .instr_word            (instr_word),
   .bank_pointer_register (bank_pointer_register),
   .ext_set_en            (ext_set_en),
   .index_base            (index_base),
   .mem_addr_ff           (mem_addr_ff),
   .mem_rd_ff             (mem_rd_ff),
   .mem_wr_ff             (mem_wr_ff),
   .w_ff                  (w_ff),
   .done_ff               (done_ff),
   .phase_ff              (phase_ff)
);

// ---- tb/tb_top.sv ----
// Random and corner tests of the add/mask execution block
`timescale 1ns/10ps
module tb_top;
   import exec_pkg::*;
   logic        mclk = 0, reset_n = 0, instr_valid = 0, ext_set_en = 0;
   logic [15:0] instr_word = '0;
   logic [3:0]  bank_pointer_register = '0;
   addr_t       index_base = '0, mem_addr_ff;
   byte_t       mem_rdata = '0, w_ff, mem_wdata_ff, w = '0, m, f;
   logic        mem_rd_ff, mem_wr_ff, indexed_ff, done_ff, neg_flag_ff;
   logic        signed_wrap_flag_ff, carry_flag_ff, nibble_carry_flag_ff;
   logic        zero_flag_ff;
   phase_e      phase_ff;
   logic [4:0]  fl = '0;
   logic [8:0]  s;
   logic [31:0] r = 32'h13d0518f;
   int          mismatches = 0, checked = 0;
   wire  [4:0]  fo = {neg_flag_ff, signed_wrap_flag_ff, carry_flag_ff,
                      nibble_carry_flag_ff, zero_flag_ff};
   always #5 mclk = ~mclk;
   add_carry_and_mask_exec u_dut
   (
      .mclk                  (mclk),
      .reset_n               (reset_n),
      .instr_valid           (instr_valid),
      .instr_word            (instr_word),
      .bank_pointer_register (bank_pointer_register),
      .ext_set_en            (ext_set_en),
      .index_base            (index_base),
      .mem_rdata             (mem_rdata),
      .mem_addr_ff           (mem_addr_ff),
      .mem_rd_ff             (mem_rd_ff),
      .mem_wr_ff             (mem_wr_ff),
      .mem_wdata_ff          (mem_wdata_ff),
      .indexed_ff            (indexed_ff),
      .w_ff                  (w_ff),
      .neg_flag_ff           (neg_flag_ff),
      .signed_wrap_flag_ff   (signed_wrap_flag_ff),
      .carry_flag_ff         (carry_flag_ff),
      .nibble_carry_flag_ff  (nibble_carry_flag_ff),
      .zero_flag_ff          (zero_flag_ff),
      .done_ff               (done_ff),
      .phase_ff              (phase_ff)
   );
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   function automatic addr_t ea(input byte_t f, input logic a, e,
                                input addr_t b, input logic [3:0] p);
      if (a) return {p, f};
      if (e && f <= 8'h5f) return b + f;
      return {f[7] ? 4'hf : 4'h0, f};
   endfunction
   task automatic print_verdict;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [11:0] e, g);
      checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic op(input logic [15:0] iw);
      int i;
      instr_valid <= 1'b1;
      instr_word  <= iw;
      mem_rdata   <= m;
      @(posedge mclk);
      instr_valid <= 1'b0;
      for (i = 0; i < 6 && done_ff !== 1'b1; i++)
      begin
         @(posedge mclk);
         #1;
      end
      if (i == 6)
      begin
         mismatches++;
         print_verdict;
      end
   endtask
   initial
   begin
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      for (int n = 0; n < 80; n++)
      begin
         r = xs(r);
         // Carry chain corners first
         if (n < 4) r[27:0] = {n[0] ? 8'h01 : 8'hff, r[19:4], 4'h0};
         f = r[4] ? r[15:8] : 8'h5f + r[5];
         m = r[27:20];
         @(posedge mclk);
         bank_pointer_register <= r[19:16];
         ext_set_en <= r[6];
         index_base <= r[31:20];
         if (r[7])
         begin
            // Foreign opcode in Q1 must leave everything alone
            instr_valid <= 1'b1;
            instr_word  <= {4'h9, r[11:0]};
            @(posedge mclk);
         end
         if (r[0])
         begin
            op({8'h0b, f});
            w = w & f;
            fl = {w[7], fl[3:1], w == 8'h00};
         end
         else
         begin
            op({6'h08, r[2], r[3], f});
            s = w + m + fl[2];
            fl = {s[7], w[7] == m[7] && s[7] != w[7], s[8],
                  s[4] ^ w[4] ^ m[4], s[7:0] == 8'h00};
            if (!r[2]) w = s[7:0];
            chk("wr", r[2], mem_wr_ff);
            if (r[2]) chk("wdata", s[7:0], mem_wdata_ff);
            chk("addr", ea(f, r[3], r[6], r[31:20], r[19:16]),
                mem_addr_ff);
            chk("indexed", !r[3] && r[6] && f <= 8'h5f, indexed_ff);
         end
         chk("w", w, w_ff);
         chk("flags", fl, fo);
         chk("phase", PH_Q4, phase_ff);
      end
      print_verdict;
   end
endmodule
